// [hdl/aos_adapter.sv]
// Functional notes
// - Card-enable bit and second enable both needed
// - Provide software-controlled second enable
// - Low byte of sixteen-bit subaddress selects on-card store
// - Subaddress advances after each option byte 3 write
// - Host masks interrupts, selects, reads identity
// - Write byte 1 with enable clear disables
// - Host writes bytes 2-4, then enables
// - Host deselects, then unmasks interrupts
// - Normal accesses answered only while enabled
// - Ordinary writes never touch option latches
// - Sixteen-bit identity, four option bytes
// - Setup decoded only while selected, A2-A0
// - Disabled: ignore cycles, no interrupt requests
// - Identity bytes read-only, single-byte transfers
//
// Adapter end: option latches, identity, subaddress counter and on-card store.
// Assumes setup signals come from logic on core_clk.
// Second enable, function requests and channel-check event also come from logic on core_clk.
`timescale 1ns/1ps
module aos_adapter #(
	parameter logic [15:0] ADAPTER_ID = aos_pkg::ID_DEFAULT // Arbitrary value
) (
	input  wire logic       core_clk,
	input  wire logic       reset,
	aos_if.adapter          bus,
	input  wire logic       second_enable,
	input  wire logic       func_req,
	input  wire logic       func_irq_src,
	input  wire logic       chk_event,
	output logic            card_active,
	output logic            func_ack,
	output logic            func_irq,
	output logic [7:0]      opt2_out,
	output logic [7:0]      opt3_out,
	output logic [15:0]     subaddress_bits
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [7:0]  opt1_reg,  opt1_next;
	logic [7:0]  opt2_reg,  opt2_next;
	logic [7:0]  opt3_reg,  opt3_next;
	logic [7:0]  opt4_reg,  opt4_next;
	logic [15:0] sub_reg,   sub_next;
	logic [7:0]  rdata_reg, rdata_next;
	logic        act_reg,   act_next;
	logic        ack_reg,   ack_next;
	logic        irq_reg,   irq_next;
	logic [7:0]  store_mem [aos_pkg::STORE_DEPTH];
	logic        store_we;
	logic [7:0]  store_addr;
	logic [7:0]  store_wdata;
	logic        sel;
	logic        wr_setup;
	logic        rd_setup;
	logic        enabled;

	// ----------------------------------------
	// Setup decode
	// ----------------------------------------
	assign sel      = !bus.slot_setup_select_n;
	assign wr_setup = sel && bus.io_wr;
	assign rd_setup = sel && bus.io_rd;
	assign enabled  = opt1_reg[aos_pkg::CARD_EN_POS] && second_enable;

	// ----------------------------------------
	// Option latches
	// ----------------------------------------
	always_comb begin
		opt1_next = opt1_reg;
		opt2_next = opt2_reg;
		opt3_next = opt3_reg;
		opt4_next = opt4_reg;
		if (wr_setup) begin
			if (bus.addr == aos_pkg::ADDR_OPT1) begin
				opt1_next = bus.wdata;
			end else if (bus.addr == aos_pkg::ADDR_OPT2) begin
				opt2_next = bus.wdata;
			end else if (bus.addr == aos_pkg::ADDR_OPT3) begin
				opt3_next = bus.wdata;
			end else if (bus.addr == aos_pkg::ADDR_OPT4) begin
				opt4_next = bus.wdata;
			end
		end
		// Channel-check indicator cleared by an event and held low until rewritten; the event wins over a write
		if (chk_event) begin
			opt4_next[aos_pkg::CHK_ACT_POS] = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			opt1_reg <= aos_pkg::OPT1_RESET;
			opt2_reg <= aos_pkg::OPT_RESET;
			opt3_reg <= aos_pkg::OPT_RESET;
			opt4_reg <= aos_pkg::OPT4_RESET;
		end else begin
			opt1_reg <= opt1_next;
			opt2_reg <= opt2_next;
			opt3_reg <= opt3_next;
			opt4_reg <= opt4_next;
		end
	end

	// ----------------------------------------
	// Subaddress counter and on-card store
	// ----------------------------------------
	always_comb begin
		sub_next    = sub_reg;
		store_we    = 1'b0;
		store_addr  = sub_reg[7:0];
		store_wdata = bus.wdata;
		if (wr_setup) begin
			if (bus.addr == aos_pkg::ADDR_OPT3) begin
				store_we = 1'b1;
				sub_next = sub_reg + 16'h0001;
			end else if (bus.addr == aos_pkg::ADDR_SUB_LO) begin
				sub_next = {sub_reg[15:8], bus.wdata};
			end else if (bus.addr == aos_pkg::ADDR_SUB_HI) begin
				sub_next = {bus.wdata, sub_reg[7:0]};
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			sub_reg <= aos_pkg::SUB_RESET;
		end else begin
			sub_reg <= sub_next;
		end
	end

	// Store has no reset; the host loads it before reading it back
	always_ff @(posedge core_clk) begin
		if (store_we) begin
			store_mem[store_addr] <= store_wdata;
		end
	end

	// ----------------------------------------
	// Setup read data
	// ----------------------------------------
	always_comb begin
		rdata_next = 8'h00;
		if (rd_setup) begin
			if (bus.addr == aos_pkg::ADDR_ID_LO) begin
				rdata_next = ADAPTER_ID[7:0];
			end else if (bus.addr == aos_pkg::ADDR_ID_HI) begin
				rdata_next = ADAPTER_ID[15:8];
			end else if (bus.addr == aos_pkg::ADDR_OPT1) begin
				rdata_next = opt1_reg;
			end else if (bus.addr == aos_pkg::ADDR_OPT2) begin
				rdata_next = opt2_reg;
			end else if (bus.addr == aos_pkg::ADDR_OPT3) begin
				// Option byte 3 reads back the store, not its latch
				rdata_next = store_mem[sub_reg[7:0]];
			end else if (bus.addr == aos_pkg::ADDR_OPT4) begin
				rdata_next = opt4_reg;
			end else if (bus.addr == aos_pkg::ADDR_SUB_LO) begin
				rdata_next = sub_reg[7:0];
			end else begin
				rdata_next = sub_reg[15:8];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	// ----------------------------------------
	// Normal-access gating
	// ----------------------------------------
	// A disabled card drops its acknowledge and interrupt one cycle later
	always_comb begin
		act_next = enabled;
		ack_next = enabled && func_req;
		irq_next = enabled && func_irq_src;
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			act_reg <= 1'b0;
			ack_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else begin
			act_reg <= act_next;
			ack_reg <= ack_next;
			irq_reg <= irq_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign bus.rdata       = rdata_reg;
	assign card_active     = act_reg;
	assign func_ack        = ack_reg;
	assign func_irq        = irq_reg;
	assign opt2_out        = opt2_reg;
	assign opt3_out        = opt3_reg;
	assign subaddress_bits = sub_reg;
endmodule

// [hdl/aos_host.sv]
// Host end: runs the setup sequence for one slot.
// Assumes start is a one-cycle pulse on core_clk; option bytes are held stable while busy.
`timescale 1ns/1ps
module aos_host (
	input  wire logic       core_clk,
	input  wire logic       reset,
	aos_if.host             bus,
	input  wire logic       start,
	input  wire logic [7:0] opt1_val,
	input  wire logic [7:0] opt2_val,
	input  wire logic [7:0] opt3_val,
	input  wire logic [7:0] opt4_val,
	output logic            irq_mask,
	output logic            busy,
	output logic            done,
	output logic [15:0]     id_read
);
	aos_pkg::aos_host_state_t state_reg, state_next;
	logic        sel_n_reg, sel_n_next;
	logic [2:0]  addr_reg,  addr_next;
	logic [7:0]  wdata_reg, wdata_next;
	logic        wr_reg,    wr_next;
	logic        rd_reg,    rd_next;
	logic        mask_reg,  mask_next;
	logic        done_reg,  done_next;
	logic        busy_reg,  busy_next;
	logic [15:0] id_reg,    id_next;

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		sel_n_next = sel_n_reg;
		addr_next  = addr_reg;
		wdata_next = 8'h00;
		wr_next    = 1'b0;
		rd_next    = 1'b0;
		mask_next  = mask_reg;
		done_next  = 1'b0;
		id_next    = id_reg;
		case (state_reg)
			aos_pkg::AOS_IDLE: begin
				if (start) begin
					mask_next  = 1'b1;
					sel_n_next = 1'b0;
					state_next = aos_pkg::AOS_SEL;
				end
			end
			aos_pkg::AOS_SEL: begin
				addr_next  = aos_pkg::ADDR_ID_LO;
				rd_next    = 1'b1;
				state_next = aos_pkg::AOS_ID_LO;
			end
			aos_pkg::AOS_ID_LO: begin
				addr_next  = aos_pkg::ADDR_ID_HI;
				rd_next    = 1'b1;
				state_next = aos_pkg::AOS_ID_HI;
			end
			aos_pkg::AOS_ID_HI: begin
				id_next[7:0] = bus.rdata;
				addr_next    = aos_pkg::ADDR_OPT1;
				wdata_next   = opt1_val & 8'hFE;
				wr_next      = 1'b1;
				state_next   = aos_pkg::AOS_DIS;
			end
			aos_pkg::AOS_DIS: begin
				id_next[15:8] = bus.rdata;
				addr_next     = aos_pkg::ADDR_OPT2;
				wdata_next    = opt2_val;
				wr_next       = 1'b1;
				state_next    = aos_pkg::AOS_OPT2;
			end
			aos_pkg::AOS_OPT2: begin
				addr_next  = aos_pkg::ADDR_OPT3;
				wdata_next = opt3_val;
				wr_next    = 1'b1;
				state_next = aos_pkg::AOS_OPT3;
			end
			aos_pkg::AOS_OPT3: begin
				addr_next  = aos_pkg::ADDR_OPT4;
				wdata_next = opt4_val;
				wr_next    = 1'b1;
				state_next = aos_pkg::AOS_OPT4;
			end
			aos_pkg::AOS_OPT4: begin
				addr_next  = aos_pkg::ADDR_OPT1;
				wdata_next = opt1_val | 8'h01;
				wr_next    = 1'b1;
				state_next = aos_pkg::AOS_EN;
			end
			aos_pkg::AOS_EN: begin
				sel_n_next = 1'b1;
				state_next = aos_pkg::AOS_DESEL;
			end
			aos_pkg::AOS_DESEL: begin
				mask_next  = 1'b0;
				done_next  = 1'b1;
				state_next = aos_pkg::AOS_DONE;
			end
			default: begin
				state_next = aos_pkg::AOS_IDLE;
			end
		endcase
		busy_next = (state_next != aos_pkg::AOS_IDLE);
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_reg <= aos_pkg::AOS_IDLE;
			sel_n_reg <= 1'b1;
			addr_reg  <= 3'h0;
			wdata_reg <= 8'h00;
			wr_reg    <= 1'b0;
			rd_reg    <= 1'b0;
			mask_reg  <= 1'b0;
			done_reg  <= 1'b0;
			busy_reg  <= 1'b0;
			id_reg    <= 16'h0000;
		end else begin
			state_reg <= state_next;
			sel_n_reg <= sel_n_next;
			addr_reg  <= addr_next;
			wdata_reg <= wdata_next;
			wr_reg    <= wr_next;
			rd_reg    <= rd_next;
			mask_reg  <= mask_next;
			done_reg  <= done_next;
			busy_reg  <= busy_next;
			id_reg    <= id_next;
		end
	end

	assign bus.slot_setup_select_n = sel_n_reg;
	assign bus.addr                = addr_reg;
	assign bus.wdata               = wdata_reg;
	assign bus.io_wr               = wr_reg;
	assign bus.io_rd               = rd_reg;
	assign irq_mask                = mask_reg;
	assign busy                    = busy_reg;
	assign done                    = done_reg;
	assign id_read                 = id_reg;
endmodule

// [inc/aos_if.sv]
// Interface joining the setup host end and the adapter end.
// Assumes a single clock; the host drives address and strobes, the adapter returns read data next cycle.
`timescale 1ns/1ps
interface aos_if (
	input wire logic core_clk
);
	logic       slot_setup_select_n;
	logic [2:0] addr;
	logic [7:0] wdata;
	logic       io_wr;
	logic       io_rd;
	logic [7:0] rdata;
	modport host (
		output slot_setup_select_n,
		output addr,
		output wdata,
		output io_wr,
		output io_rd,
		input  rdata
	);
	modport adapter (
		input  slot_setup_select_n,
		input  addr,
		input  wdata,
		input  io_wr,
		input  io_rd,
		output rdata
	);
endinterface

// [inc/aos_pkg.sv]
// Package for the adapter option-select setup block: setup addresses, field positions, reset values.
// Assumes both ends are built on the one core clock.
package aos_pkg;
	// ----------------------------------------
	// Setup register indices (A2..A0)
	// ----------------------------------------
	localparam logic [2:0]  ADDR_ID_LO    = 3'h0;
	localparam logic [2:0]  ADDR_ID_HI    = 3'h1;
	localparam logic [2:0]  ADDR_OPT1     = 3'h2;
	localparam logic [2:0]  ADDR_OPT2     = 3'h3;
	localparam logic [2:0]  ADDR_OPT3     = 3'h4;
	localparam logic [2:0]  ADDR_OPT4     = 3'h5;
	localparam logic [2:0]  ADDR_SUB_LO   = 3'h6;
	localparam logic [2:0]  ADDR_SUB_HI   = 3'h7;
	localparam logic [15:0] SETUP_BASE    = 16'h0100;
	// ----------------------------------------
	// Fields and reset values
	// ----------------------------------------
	localparam int          CARD_EN_POS   = 0;
	localparam int          CHK_ACT_POS   = 7;
	localparam int          CHK_STAT_POS  = 6;
	localparam logic [7:0]  OPT1_RESET    = 8'h00;
	localparam logic [7:0]  OPT_RESET     = 8'h00;
	localparam logic [7:0]  OPT4_RESET    = 8'hC0;
	localparam logic [15:0] SUB_RESET     = 16'h0000;
	localparam logic [15:0] ID_DEFAULT    = 16'h5A5A;
	localparam int          STORE_DEPTH   = 256;
	// ----------------------------------------
	// Host sequencer states
	// ----------------------------------------
	typedef enum logic [3:0] {
		AOS_IDLE   = 4'h0,
		AOS_SEL    = 4'h1,
		AOS_ID_LO  = 4'h3,
		AOS_ID_HI  = 4'h2,
		AOS_DIS    = 4'h6,
		AOS_OPT2   = 4'h7,
		AOS_OPT3   = 4'h5,
		AOS_OPT4   = 4'h4,
		AOS_EN     = 4'hC,
		AOS_DESEL  = 4'hD,
		AOS_DONE   = 4'hF
	} aos_host_state_t;
endpackage

// [verification/aos_check_sva.sv]
// Checker for the setup bus between host end and adapter end.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module aos_check #(
	parameter logic [15:0] ADAPTER_ID = aos_pkg::ID_DEFAULT // Arbitrary value
) (
	input wire logic       core_clk,
	input wire logic       reset,
	input wire logic       slot_setup_select_n,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       io_wr,
	input wire logic       io_rd,
	input wire logic [7:0] rdata
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	property p_rd_idle; (!io_rd || slot_setup_select_n) |=> rdata == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
	property p_one_strobe; !(io_wr && io_rd); endproperty
	a_one_strobe: assert property (p_one_strobe) else $error("two strobes at once");
	property p_strobe_sel; (io_wr || io_rd) |-> !slot_setup_select_n; endproperty
	a_strobe_sel: assert property (p_strobe_sel) else $error("strobe while unselected");
	property p_first_read; $fell(slot_setup_select_n) |=> io_rd && addr == 3'h0; endproperty
	a_first_read: assert property (p_first_read) else $error("identity not read first");
	property p_id_lo; io_rd && !slot_setup_select_n && addr == 3'h0 |=> rdata == ADAPTER_ID[7:0]; endproperty
	a_id_lo: assert property (p_id_lo) else $error("identity low wrong");
	property p_id_hi; io_rd && !slot_setup_select_n && addr == 3'h1 |=> rdata == ADAPTER_ID[15:8]; endproperty
	a_id_hi: assert property (p_id_hi) else $error("identity high wrong");
	property p_order;
		io_wr && addr == 3'h2 && !wdata[0] |=> io_wr && addr == 3'h3 ##1 io_wr && addr == 3'h4
			##1 io_wr && addr == 3'h5 ##1 io_wr && addr == 3'h2 && wdata[0];
	endproperty
	a_order: assert property (p_order) else $error("option write order wrong");
	property p_desel; io_wr && addr == 3'h2 && wdata[0] |=> slot_setup_select_n && !io_wr && !io_rd; endproperty
	a_desel: assert property (p_desel) else $error("no deselect after enable");
endmodule

// [verification/tb_adapter_option_select_setup.sv]
// Testbench: host and adapter joined; a second adapter driven directly by the bench.
// Assumes the design package and interface are compiled first.
`timescale 1ns/1ps
module tb_adapter_option_select_setup;
	localparam logic [15:0] ID = 16'hC3A5; // Arbitrary value
	logic        core_clk = 1'b0;
	logic        reset = 1'b1;
	logic        start = 1'b0;
	logic        se = 1'b1;
	logic        fr = 1'b0;
	logic        fi = 1'b0;
	logic        ce = 1'b0;
	logic [7:0]  ov [4];
	logic        card_a, ack_a, irq_a, card_b, ack_b, irq_b, irq_mask, busy, done;
	logic [7:0]  o2_a, o3_a, o2_b, r;
	logic [15:0] sub_a, sub_b, id_rd, k;
	int          failures = 0, cmp_count = 0, seed = 58381, msub = 0, n;
	int          mstore [int];
	aos_if b0 (.core_clk(core_clk));
	aos_if b1 (.core_clk(core_clk));
	aos_host u_aos_host (.core_clk(core_clk), .reset(reset), .bus(b0), .start(start), .opt1_val(ov[0]),
		.opt2_val(ov[1]), .opt3_val(ov[2]), .opt4_val(ov[3]), .irq_mask(irq_mask), .busy(busy),
		.done(done), .id_read(id_rd));
	aos_adapter #(.ADAPTER_ID(ID)) u_aos_adapter (.core_clk(core_clk), .reset(reset), .bus(b0),
		.second_enable(se), .func_req(fr), .func_irq_src(fi), .chk_event(ce), .card_active(card_a),
		.func_ack(ack_a), .func_irq(irq_a), .opt2_out(o2_a), .opt3_out(o3_a), .subaddress_bits(sub_a));
	aos_adapter #(.ADAPTER_ID(ID)) u_aos_adapter_b (.core_clk(core_clk), .reset(reset), .bus(b1),
		.second_enable(se), .func_req(fr), .func_irq_src(fi), .chk_event(ce), .card_active(card_b),
		.func_ack(ack_b), .func_irq(irq_b), .opt2_out(o2_b), .opt3_out(), .subaddress_bits(sub_b));
	aos_check #(.ADAPTER_ID(ID)) u_aos_check (.core_clk(core_clk), .reset(reset),
		.slot_setup_select_n(b0.slot_setup_select_n), .addr(b0.addr), .wdata(b0.wdata),
		.io_wr(b0.io_wr), .io_rd(b0.io_rd), .rdata(b0.rdata));
	always #2.5 core_clk = ~core_clk;
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task summarize;
		$display("compares %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task tick(input int c);
		repeat (c) @(posedge core_clk);
		#1;
	endtask
	task wr(input logic sn, input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk);
		b1.slot_setup_select_n <= sn; b1.addr <= a; b1.wdata <= d; b1.io_wr <= 1'b1;
		@(posedge core_clk);
		b1.io_wr <= 1'b0; b1.slot_setup_select_n <= 1'b1;
		if (!sn && a == 3'h4) begin
			mstore[msub & 255] = d;
			msub = (msub + 1) & 16'hFFFF;
		end
		if (!sn && a == 3'h6) msub = (msub & 16'hFF00) | d;
		if (!sn && a == 3'h7) msub = (msub & 16'h00FF) | (d << 8);
	endtask
	task rd(input logic [2:0] a, output logic [7:0] q);
		@(posedge core_clk);
		b1.slot_setup_select_n <= 1'b0; b1.addr <= a; b1.io_rd <= 1'b1;
		@(posedge core_clk);
		b1.io_rd <= 1'b0; b1.slot_setup_select_n <= 1'b1;
		#1 q = b1.rdata;
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		b1.slot_setup_select_n = 1'b1; b1.addr = 3'h0; b1.wdata = 8'h00; b1.io_wr = 1'b0; b1.io_rd = 1'b0;
		foreach (ov[i]) ov[i] = 8'($random(seed));
		repeat (8) @(posedge core_clk);
		reset <= 1'b0; fr <= 1'b1; fi <= 1'b1;
		tick(2);
		chk(card_a, 16'h0000);
		chk({ack_a, irq_a}, 16'h0000);
		@(posedge core_clk) start <= 1'b1;
		@(posedge core_clk) start <= 1'b0;
		tick(1);
		chk(busy, 16'h0001);
		for (n = 0; n < 40 && done !== 1'b1; n++) tick(1);
		if (n == 40) begin failures++; summarize; end
		chk(irq_mask, 16'h0000);
		chk(id_rd, ID);
		tick(2);
		chk(busy, 16'h0000);
		chk({card_a, ack_a}, 16'h0003);
		chk({o2_a, o3_a}, {ov[1], ov[2]});
		chk(sub_a, 16'h0001);
		@(posedge core_clk) se <= 1'b0;
		tick(2);
		chk({card_a, irq_a}, 16'h0000);
		@(posedge core_clk) se <= 1'b1;
		rd(3'h0, r); chk(r, ID[7:0]);
		wr(1'b0, 3'h1, ~ID[15:8]); rd(3'h1, r); chk(r, ID[15:8]);
		wr(1'b1, 3'h2, 8'h01); tick(3); chk(card_b, 16'h0000);
		wr(1'b0, 3'h6, 8'hFE); wr(1'b0, 3'h7, 8'h12);
		for (int i = 0; i < 3; i++) wr(1'b0, 3'h4, 8'($random(seed)));
		tick(1); chk(sub_b, 16'(msub));
		for (int i = 0; i < 3; i++) begin
			k = 16'h12FE + 16'(i);
			wr(1'b0, 3'h6, k[7:0]); wr(1'b0, 3'h7, k[15:8]);
			rd(3'h4, r); chk(r, 16'(mstore[msub & 255]));
		end
		wr(1'b0, 3'h2, 8'h01); wr(1'b1, 3'h3, 8'hA5); wr(1'b1, 3'h2, 8'h00); tick(3);
		chk({card_b, ack_b}, 16'h0003);
		chk(o2_b, 16'h0000);
		wr(1'b0, 3'h2, 8'h00); tick(3);
		chk({card_b, ack_b, irq_b}, 16'h0000);
		rd(3'h5, r); chk(r, 16'(aos_pkg::OPT4_RESET));
		@(posedge core_clk) ce <= 1'b1;
		@(posedge core_clk) ce <= 1'b0;
		rd(3'h5, r); chk(r, 16'(aos_pkg::OPT4_RESET) & 16'h007F);
		wr(1'b0, 3'h5, aos_pkg::OPT4_RESET); rd(3'h5, r); chk(r, 16'(aos_pkg::OPT4_RESET));
		wr(1'b0, 3'h2, 8'h01); tick(3);
		@(posedge core_clk) reset <= 1'b1;
		tick(2);
		@(posedge core_clk) reset <= 1'b0;
		tick(1);
		chk(card_b, 16'h0000);
		chk(sub_b, 16'h0000);
		summarize;
	end
	initial begin
		#200000;
		failures++;
		summarize;
	end
endmodule
